// file: verilog/sat_schedule_alarm_timer.sv
// Schedule alarm timer: 16-bit prescaled up-counter with alarm compare,
// external sync clear and an APB register slave.
// Assumes pclk is the system clock and the sync pin is asynchronous to it.
// Assumes the bus master follows APB; this slave never inserts wait states.
// Reset is asynchronous on assert and used synchronously after release.
//
// Added by the designer: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// R1: Tick is pclk divided by two to the power of the prescale field.
// R2: Counter is 16-bit, up-counting, readable at any time.
// R3: Counter advances on each tick while run enable is 1, else holds.
// R4: Control bit 0 is the run enable.
// R5: Software write to count register loads the counter directly.
// R6: Control bit 1 enables the alarm compare.
// R7: Alarm flag bit 6 sets when running, alarm enabled and count equals alarm.
// R8: Alarm match clears the counter in the same cycle as flag set.
// R9: Alarm interrupt request is flag and interrupt enable bit 7.
// R10: Bit 8 arms external sync; hardware clears it after one event.
// R11: Armed sync rising edge clears the counter on the third clock after the pin rises.
// R12: Sync source holds the pin high at least one clock after rising.
// R13: Reserved control bits read zero and ignore writes.
// R14: Every reset clears counter, alarm, flag, prescale and enables.
// R15: Alarm register is writable only while run or alarm enable is 1.
// R16: Alarm interrupt also serves as a stop-mode wake source.
// R17: Counter wraps from FFFF to zero.
// R18: Flag stays set until written 0; writing 1 sets it.
// R19: Sync pin passes a two-stage synchroniser before edge detect.
module sat_schedule_alarm_timer
  import sat_pkg::*;
#(
  parameter int CNT_W = 16
) (
  // APB clock and reset
  input  wire  logic        pclk,
  input  wire  logic        presetn,
  // APB slave
  input  wire  logic        psel,
  input  wire  logic        penable,
  input  wire  logic        pwrite,
  input  wire  logic [11:0] paddr,
  input  wire  logic [31:0] pwdata,
  input  wire  logic [3:0]  pstrb,
  output logic        [31:0] prdata,
  output logic              pready,
  output logic              pslverr,
  // External sync pin
  input  wire  logic        external_sync_pin,
  // Interrupts
  output logic              irq,
  output logic              alarm_irq_req,
  output logic              wake_req
);

  if (CNT_W != 16) begin : g_chk
    $error("sat_schedule_alarm_timer supports only CNT_W of 16");
  end

  // Prescale field must be three bits wide for the divider mask
  if ((SAT_CTL_PS_HI - SAT_CTL_PS_LO) != 2) begin : g_chk_ps
    $error("sat_schedule_alarm_timer needs a three-bit prescale field");
  end

  // Status holds exactly the three event sources
  if (SAT_IRQ_W != 3) begin : g_chk_irq
    $error("sat_schedule_alarm_timer needs three interrupt sources");
  end

  // Flag must be writable so software can clear and test it
  if (SAT_CTL_WMASK[SAT_CTL_FLAG] != 1'b1) begin : g_chk_flag
    $error("sat_schedule_alarm_timer needs the flag bit writable");
  end

  // Enables and sync arm must all be writable
  if ((SAT_CTL_WMASK[SAT_CTL_RUN] & SAT_CTL_WMASK[SAT_CTL_ALMEN]
       & SAT_CTL_WMASK[SAT_CTL_IRQEN] & SAT_CTL_WMASK[SAT_CTL_SYNC]) != 1'b1) begin : g_chk_en
    $error("sat_schedule_alarm_timer needs all enable bits writable");
  end

  // Control reset value must clear every field
  if (SAT_RESET_VAL != 16'h0000) begin : g_chk_rst
    $error("sat_schedule_alarm_timer needs a zero control reset value");
  end

  // Timer register indices must not overlap
  if ((SAT_IDX_COUNT == SAT_IDX_CONTROL) || (SAT_IDX_ALARM == SAT_IDX_COUNT)) begin : g_chk_tix
    $error("sat_schedule_alarm_timer needs distinct timer register indices");
  end

  // Interrupt register indices must not overlap the timer ones
  if ((SAT_IDX_IRQ_STS == SAT_IDX_ALARM) || (SAT_IDX_IRQ_MSK == SAT_IDX_IRQ_STS)) begin : g_chk_iix
    $error("sat_schedule_alarm_timer needs distinct interrupt register indices");
  end

  // Control fields
  logic             timer_run_enable_q;
  logic             alarm_function_enable_q;
  logic             alarm_match_flag_q;
  logic             alarm_interrupt_enable_q;
  logic             external_sync_arm_q;
  logic [2:0]       tick_prescale_select_q;

  // Counter and alarm compare value
  logic [CNT_W-1:0] count_q;
  logic [CNT_W-1:0] alarm_q;

  // Divider and sync pin history
  logic [6:0]       prescale_q;
  logic [1:0]       sync_meta_q;
  logic             sync_prev_q;

  // Sticky interrupt status and its mask
  logic [SAT_IRQ_W-1:0] irq_sts_q;
  logic [SAT_IRQ_W-1:0] irq_msk_q;

  // Read data captured in the setup cycle
  logic [31:0]      prdata_q;

  // APB decode
  // Word index from the byte address; the two low bits must be zero
  // Refused accesses still complete, with an error and no side effect
  wire        acc      = psel & penable;
  wire        wr_acc   = acc & pwrite;
  wire        rd_acc   = acc & ~pwrite;
  wire [9:0]  widx     = paddr[11:2];

  // Register hits by word index
  wire        hit_ctl  = (widx == {2'b00, SAT_IDX_CONTROL});
  wire        hit_cnt  = (widx == {2'b00, SAT_IDX_COUNT});
  wire        hit_alm  = (widx == {2'b00, SAT_IDX_ALARM});
  wire        hit_sts  = (widx == {2'b00, SAT_IDX_IRQ_STS});
  wire        hit_msk  = (widx == {2'b00, SAT_IDX_IRQ_MSK});
  wire        mapped   = hit_ctl | hit_cnt | hit_alm | hit_sts | hit_msk;
  wire        misalign = (paddr[1:0] != 2'b00);
  wire        ok       = mapped & ~misalign;

  // Byte lane mask for the low half-word
  wire [15:0] lane_m   = {{8{pstrb[1]}}, {8{pstrb[0]}}};

  // Qualified register strobes
  wire        wr_ctl   = wr_acc & ok & hit_ctl;
  wire        wr_cnt   = wr_acc & ok & hit_cnt;
  wire        wr_alm   = wr_acc & ok & hit_alm
                         & (timer_run_enable_q | alarm_function_enable_q); // [R15]
  wire        wr_msk   = wr_acc & ok & hit_msk;
  wire        rd_sts   = rd_acc & ok & hit_sts;

  // Prescaled tick: divider low bits named by the prescale code all ones
  // Code 0 gives an empty mask, so every clock is then a tick
  wire [6:0] ps_mask = ~(7'h7F << tick_prescale_select_q);
  wire [6:0] ps_seen = prescale_q & ps_mask;
  wire       tick    = (ps_seen == ps_mask);                   // [R1]

  // Sync rising edge from the second synchroniser stage only
  // Edge history is taken from the second stage as well, so the
  // first stage, which may be metastable, feeds nothing else
  wire sync_rise = sync_meta_q[1] & ~sync_prev_q;              // [R19]
  wire sync_evt  = sync_rise & external_sync_arm_q;            // [R11]

  // Alarm match and counter step
  // Match looks at the present count, so the clear lands one edge later
  // A zero alarm value with both enables on matches every cycle
  // Wrap is an increment from all ones, not a load or a clear
  wire             match   = timer_run_enable_q & alarm_function_enable_q
                             & (count_q == alarm_q);           // [R7]

  // Count step on each tick while running
  wire             step    = timer_run_enable_q & tick;        // [R3]
  wire             wrap    = step & (count_q == {CNT_W{1'b1}});
  wire [CNT_W-1:0] cnt_inc = count_q + 16'h0001;               // [R17]

  // Control write data, reserved bits masked off
  // Byte lanes not strobed hold their present value
  // Reserved bits are masked after the merge, so they always read zero
  // Count and alarm merges use the same lane rule
  wire [15:0] ctl_cur = {4'h0, tick_prescale_select_q, external_sync_arm_q,
                         alarm_interrupt_enable_q, alarm_match_flag_q, 4'h0,
                         alarm_function_enable_q, timer_run_enable_q};
  wire [15:0] ctl_wr  = ((pwdata[15:0] & lane_m) | (ctl_cur & ~lane_m))
                        & SAT_CTL_WMASK;                       // [R13]

  // Merged count and alarm write values
  wire [15:0] cnt_wr  = (pwdata[15:0] & lane_m) | (count_q & ~lane_m);
  wire [15:0] alm_wr  = (pwdata[15:0] & lane_m) | (alarm_q & ~lane_m);

  // Read value of each register; upper half always zero
  wire [31:0] rd_ctl  = {16'h0000, ctl_cur};
  wire [31:0] rd_cnt  = {16'h0000, count_q};                   // [R2]
  wire [31:0] rd_alm  = {16'h0000, alarm_q};
  wire [31:0] rd_stat = {29'h0, irq_sts_q};
  wire [31:0] rd_mask = {29'h0, irq_msk_q};

  // Read mux; unmapped or misaligned addresses read zero
  wire [31:0] rd_sel  = hit_ctl ? rd_ctl  :
                        hit_cnt ? rd_cnt  :
                        hit_alm ? rd_alm  :
                        hit_sts ? rd_stat :
                        hit_msk ? rd_mask : 32'h0000_0000;
  wire [31:0] rd_mux  = ok ? rd_sel : 32'h0000_0000;

  // Interrupt events, one per status bit
  // Bit 0 alarm match, bit 1 accepted sync, bit 2 counter wrap
  wire                 evt_alarm = match;
  wire                 evt_sync  = sync_evt;
  wire                 evt_wrap  = wrap;
  wire [SAT_IRQ_W-1:0] irq_evt   = {evt_wrap, evt_sync, evt_alarm};

  // Status next value: a read clears only the bits it returned,
  // so an event landing between setup and access is not lost
  wire [SAT_IRQ_W-1:0] sts_seen  = prdata_q[SAT_IRQ_W-1:0];
  wire [SAT_IRQ_W-1:0] sts_kept  = rd_sts ? (irq_sts_q & ~sts_seen) : irq_sts_q;
  wire [SAT_IRQ_W-1:0] irq_sts_d = sts_kept | irq_evt;         // Set wins

  // Prescale divider
  // Cleared while stopped, so the first tick after a start comes
  // a full divide period later and every run starts in phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prescale_q <= 7'h00;
    end else if (!timer_run_enable_q) begin
      prescale_q <= 7'h00;
    end else begin
      prescale_q <= prescale_q + 7'h01;
    end
  end

  // Two-stage synchroniser and edge history
  // Pin is asynchronous to pclk; only the second stage is used,
  // and a pulse shorter than a clock may be missed
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_meta_q <= 2'b00;
      sync_prev_q <= 1'b0;
    end else begin
      sync_meta_q <= {sync_meta_q[0], external_sync_pin};     // [R19]
      sync_prev_q <= sync_meta_q[1];
    end
  end

  // Counter: sync or match clear beats software load and tick
  // A load in the same cycle as a clear is lost; software that
  // writes the count near the alarm value must allow for this
  // A load also takes priority over the tick of that cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_q <= 16'h0000;                                     // [R14]
    end else if (sync_evt || match) begin
      count_q <= 16'h0000;                                     // [R8] [R11]
    end else if (wr_cnt) begin
      count_q <= cnt_wr;                                       // [R5]
    end else if (step) begin
      count_q <= cnt_inc;                                      // [R3] [R17]
    end
  end

  // Alarm value
  // Writes while both enables are 0 are dropped without an error
  // Byte lanes not strobed hold their present value
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alarm_q <= 16'h0000;                                     // [R14]
    end else if (wr_alm) begin
      alarm_q <= alm_wr;                                       // [R15]
    end
  end

  // Control enables and prescale code
  // Flag and sync arm have their own processes, since hardware
  // sets or clears them as well as software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_run_enable_q       <= 1'b0;                        // [R14]
      alarm_function_enable_q  <= 1'b0;
      alarm_interrupt_enable_q <= 1'b0;
      tick_prescale_select_q   <= 3'h0;
    end else if (wr_ctl) begin
      timer_run_enable_q       <= ctl_wr[SAT_CTL_RUN];         // [R4]
      alarm_function_enable_q  <= ctl_wr[SAT_CTL_ALMEN];       // [R6]
      alarm_interrupt_enable_q <= ctl_wr[SAT_CTL_IRQEN];
      tick_prescale_select_q   <= ctl_wr[SAT_CTL_PS_HI:SAT_CTL_PS_LO];
    end
  end

  // Alarm flag: hardware set wins over a software clear
  // Software may write 1 to test the interrupt path; writing 0
  // in the cycle of a match leaves the flag set
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alarm_match_flag_q <= 1'b0;
    end else if (match) begin
      alarm_match_flag_q <= 1'b1;                              // [R7]
    end else if (wr_ctl) begin
      alarm_match_flag_q <= ctl_wr[SAT_CTL_FLAG];              // [R18]
    end
  end

  // Sync arm: cleared by an accepted event, even against a write
  // Each arming catches one event; a rearm written in the event
  // cycle is dropped and must be repeated
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      external_sync_arm_q <= 1'b0;
    end else if (sync_evt) begin
      external_sync_arm_q <= 1'b0;                             // [R10]
    end else if (wr_ctl) begin
      external_sync_arm_q <= ctl_wr[SAT_CTL_SYNC];
    end
  end

  // Sticky status, cleared by read; new event wins over clear
  // Mask takes only the low byte lane; its upper bits do not exist
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_sts_q <= SAT_IRQ_RESET;
      irq_msk_q <= SAT_IRQ_RESET;
    end else begin
      irq_sts_q <= irq_sts_d;
      if (wr_msk && pstrb[0]) begin
        irq_msk_q <= pwdata[SAT_IRQ_W-1:0];
      end
    end
  end

  // Read data register
  // Captured in the setup cycle so prdata stands through the access
  // cycle and until the next read setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata_q <= rd_mux;
    end
  end

  // Bus answers: zero wait, error on unmapped or misaligned
  // pslverr is combinational and only high in the access cycle
  // irq sums the masked status; alarm request follows flag and enable
  assign pready        = 1'b1;
  assign pslverr       = acc & ~ok;
  assign prdata        = prdata_q;
  assign alarm_irq_req = alarm_match_flag_q & alarm_interrupt_enable_q; // [R9]
  assign wake_req      = alarm_irq_req;                        // [R16]
  assign irq           = |(irq_sts_q & irq_msk_q);

endmodule : sat_schedule_alarm_timer
`default_nettype wire

// file: verilog/sat_pkg.sv
// Package for the schedule alarm timer: register map, field layout, reset values.
// Assumes a 32-bit APB slave with one aligned word per register.
package sat_pkg;

  // Printed register indices; byte address is four times the index
  localparam logic [7:0] SAT_IDX_CONTROL = 8'h0E;
  localparam logic [7:0] SAT_IDX_COUNT   = 8'h0F;
  localparam logic [7:0] SAT_IDX_ALARM   = 8'h10;
  localparam logic [7:0] SAT_IDX_IRQ_STS = 8'h11;
  localparam logic [7:0] SAT_IDX_IRQ_MSK = 8'h12;

  // Control field positions
  localparam int SAT_CTL_RUN    = 0;
  localparam int SAT_CTL_ALMEN  = 1;
  localparam int SAT_CTL_FLAG   = 6;
  localparam int SAT_CTL_IRQEN  = 7;
  localparam int SAT_CTL_SYNC   = 8;
  localparam int SAT_CTL_PS_LO  = 9;
  localparam int SAT_CTL_PS_HI  = 11;

  // Writable control bits; reserved bits read zero
  localparam logic [15:0] SAT_CTL_WMASK = 16'h0FC3;
  localparam logic [15:0] SAT_RESET_VAL = 16'h0000;

  // Interrupt status bits: 0 alarm match, 1 sync event, 2 counter wrap
  localparam int          SAT_IRQ_W     = 3;
  localparam logic [2:0]  SAT_IRQ_RESET = 3'h0;

endpackage : sat_pkg

// file: tb/sat_properties.sv
// Port checker for the schedule alarm timer.
// Assumes it is bound to the top module; zero-wait APB slave.
`timescale 1ns/1ps
`default_nettype none
module sat_properties
  import sat_pkg::*;
#(
  parameter int CNT_W = 16
) (
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Pin and interrupts
  input wire logic        external_sync_pin,
  input wire logic        irq,
  input wire logic        alarm_irq_req,
  input wire logic        wake_req
);
  localparam logic [11:0] A_CTL = {2'h0, SAT_IDX_CONTROL, 2'h0};
  localparam logic [11:0] A_MSK = {2'h0, SAT_IDX_IRQ_MSK, 2'h0};
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Control write with given enable and flag bits
  sequence s_ctl_wr(logic [1:0] v);
    psel && penable && pwrite && paddr == A_CTL && pstrb[0] && pwdata[7:6] == v;
  endsequence
  wire rd_acc = psel && penable && !pwrite;
  property p_irq_set; s_ctl_wr(2'b11) |=> alarm_irq_req; endproperty
  a_irq_set: assert property (p_irq_set) else $error("flag write did not raise request");
  property p_irq_clr; s_ctl_wr(2'b00) |=> !alarm_irq_req; endproperty
  a_irq_clr: assert property (p_irq_clr) else $error("request stayed without enable");
  property p_rst; $rose(presetn) |-> !irq && !alarm_irq_req && prdata == 32'h0; endproperty
  a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
  property p_wake; wake_req == alarm_irq_req; endproperty
  a_wake: assert property (p_wake) else $error("wake differs from alarm request");
  property p_rsv; rd_acc && paddr == A_CTL |-> prdata[15:12] == 4'h0 && prdata[5:2] == 4'h0;
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved control bits not zero");
  property p_hi; rd_acc |-> prdata[31:16] == 16'h0; endproperty
  a_hi: assert property (p_hi) else $error("upper read data not zero");
  property p_irqrd; rd_acc && paddr == A_CTL |-> (prdata[7] && prdata[6]) == $past(alarm_irq_req);
  endproperty
  a_irqrd: assert property (p_irqrd) else $error("request disagrees with flag and enable");
  property p_err; psel && penable && (paddr < A_CTL || paddr > A_MSK) |-> pslverr; endproperty
  a_err: assert property (p_err) else $error("unmapped access not refused");
endmodule // sat_properties
`default_nettype wire

// file: tb/tb.sv
// Self-checking bench for the schedule alarm timer over APB.
// Assumes a zero-wait slave; the bench drives the sync pin itself.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import sat_pkg::*;
  localparam logic [11:0] AC = {2'h0, SAT_IDX_CONTROL, 2'h0};
  localparam logic [11:0] AN = {2'h0, SAT_IDX_COUNT, 2'h0};
  localparam logic [11:0] AA = {2'h0, SAT_IDX_ALARM, 2'h0};
  localparam logic [11:0] AS = {2'h0, SAT_IDX_IRQ_STS, 2'h0};
  localparam logic [11:0] AM = {2'h0, SAT_IDX_IRQ_MSK, 2'h0};
  logic        pclk, presetn, psel, penable, pwrite, sync_pin;
  logic        pready, pslverr, irq, air, wake, ev;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [3:0]  pstrb;
  int          err_total, n_tests, ps;
  sat_schedule_alarm_timer u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .external_sync_pin(sync_pin),
    .irq(irq), .alarm_irq_req(air), .wake_req(wake));
  // One APB transfer, then an idle edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk) penable <= 1'b1;
    n = 0;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      err_total++;
      $display("BAD pready exp 1 got %b", pready);
    end
    q = prdata;
    ev = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      err_total++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic rng(input string nm, input logic [31:0] lo, hi, g);
    n_tests++;
    if (((g >= lo) && (g <= hi)) !== 1'b1) begin
      err_total++;
      $display("BAD %s exp %h..%h got %h", nm, lo, hi, g);
    end
  endtask
  task automatic rc(input logic [11:0] a, input logic [31:0] e, input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, e, q);
  endtask
  // Sync pulse held two clocks, then settle
  task automatic pulse;
    sync_pin <= 1'b1;
    repeat (2) @(posedge pclk);
    sync_pin <= 1'b0;
    repeat (6) @(posedge pclk);
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  initial begin
    #(20000 * 50);
    err_total++;
    finish_test;
  end
  initial begin
    {presetn, psel, penable, pwrite, sync_pin, paddr, pwdata, pstrb} = {5'h00, 44'h0, 4'hF};
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rc(AC, 32'h0, "ctl");
    rc(AA, 32'h0, "alm");
    apb(1'b1, AC, 32'hF03C);
    rc(AC, 32'h0, "ctl rsv");
    rc(12'h04C, 32'h0, "unmapped");
    chk("slverr", 32'h1, {31'h0, ev});
    apb(1'b1, AA, 32'h1234);
    rc(AA, 32'h0, "alm locked");
    apb(1'b1, AC, 32'h2);
    apb(1'b1, AA, 32'h8);
    rc(AA, 32'h8, "alm open");
    apb(1'b1, AN, 32'h100);
    repeat (10) @(posedge pclk);
    rc(AN, 32'h100, "cnt hold");
    $display("test registers done");
    for (ps = 0; ps < 8; ps++) begin
      apb(1'b1, AN, 32'h0);
      apb(1'b1, AC, 32'(1 | (ps << 9)));
      repeat ((16 << ps) - 3) @(posedge pclk);
      apb(1'b1, AC, 32'h0);
      apb(1'b0, AN, 32'h0);
      rng("cnt prescale", 32'd15, 32'd17, q);
    end
    $display("test prescale done");
    apb(1'b1, AN, 32'h0);
    apb(1'b1, AC, 32'h83);
    repeat (20) @(posedge pclk);
    chk("irq req", 32'h1, {31'h0, air});
    chk("wake", 32'h1, {31'h0, wake});
    rc(AC, 32'hC3, "flag");
    apb(1'b1, AC, 32'hC2);
    apb(1'b0, AN, 32'h0);
    rng("cnt period", 32'd0, 32'd8, q);
    apb(1'b1, AC, 32'h80);
    chk("irq clr", 32'h0, {31'h0, air});
    apb(1'b1, AC, 32'h1);
    repeat (30) @(posedge pclk);
    apb(1'b1, AC, 32'h0);
    apb(1'b0, AN, 32'h0);
    rng("no alarm", 32'd30, 32'd45, q);
    $display("test alarm done");
    apb(1'b0, AS, 32'h0);
    apb(1'b1, AN, 32'hFFFE);
    apb(1'b1, AC, 32'h1);
    repeat (6) @(posedge pclk);
    chk("irq masked", 32'h0, {31'h0, irq});
    apb(1'b1, AM, 32'h4);
    chk("irq wrap", 32'h1, {31'h0, irq});
    rc(AS, 32'h4, "wrap sts");
    chk("irq read clr", 32'h0, {31'h0, irq});
    apb(1'b1, AC, 32'h0);
    apb(1'b1, AN, 32'h500);
    apb(1'b1, AC, 32'h100);
    pulse;
    rc(AN, 32'h0, "sync clr");
    rc(AC, 32'h0, "arm");
    rc(AS, 32'h2, "sync sts");
    apb(1'b1, AN, 32'h300);
    pulse;
    rc(AN, 32'h300, "one shot");
    $display("test irq and sync done");
    finish_test;
  end
endmodule // tb
bind sat_schedule_alarm_timer sat_properties #(.CNT_W(CNT_W)) u_props (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .external_sync_pin(external_sync_pin), .irq(irq), .alarm_irq_req(alarm_irq_req),
  .wake_req(wake_req));
`default_nettype wire
